/* dv/periph_event_model.sv */
// peripheral side: fires one-cycle interrupt conditions on command
module periph_event_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic      [5:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;

  initial ev = 6'h00;

  // conditions are raised just after an edge and held for exactly one edge
  task automatic pulse(input logic [5:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 6'h00;
  endtask : pulse
endmodule : periph_event_model

/* dv/test_periph_irq_ctrl.sv */
// self-checking bench for the peripheral interrupt enable and request block
module test_periph_irq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  ev;
  logic        periph_irq_req;
  logic        irq;
  logic [31:0] r;
  logic        e;
  logic [15:0] one_hot;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;

  always #2 pclk = ~pclk;

  // ev: 5 gate, 4 adc, 3 rx, 2 tx, 1 lcd, 0 overflow
  periph_irq_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .timer1_gate_event(ev[5]), .adc_event(ev[4]), .serial_rx_event(ev[3]),
    .serial_tx_event(ev[2]), .lcd_event(ev[1]), .timer1_overflow_event(ev[0]),
    .periph_irq_req(periph_irq_req), .irq(irq)
  );

  periph_event_model peer (.pclk(pclk), .presetn(presetn), .ev(ev));

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    // far above the few hundred cycles the sequence needs
    if (cycles == 4000) begin
      fail_count++;
      conclude;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: a stuck slave is caught by the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expected request bits of one event: [7:0] bank a, [15:8] bank b
  function automatic logic [15:0] ev_bits(input int i);
    logic [15:0] v;
    v = 16'h0000;
    case (i)
      5:       v[irq_regs_pkg::BIT_T1_GATE]  = 1'b1;
      4:       v[irq_regs_pkg::BIT_ADC]      = 1'b1;
      3:       v[irq_regs_pkg::BIT_RX]       = 1'b1;
      2:       v[irq_regs_pkg::BIT_TX]       = 1'b1;
      1:       v[8 + irq_regs_pkg::BIT_LCD]  = 1'b1;
      default: v[irq_regs_pkg::BIT_T1_OVF]   = 1'b1;
    endcase
    return v;
  endfunction : ev_bits

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rd

  // registered outputs trail a committed write by one edge
  task automatic out_chk(input logic got_req, input logic req, input logic got_irq,
                         input logic ex_irq);
    chk(32'(got_req), 32'(req));
    chk(32'(got_irq), 32'(ex_irq));
  endtask : out_chk

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic zero_all;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0000_0000);
  endtask : zero_all

  initial begin
    do_reset;
    zero_all;
    wr(irq_regs_pkg::OFF_EN_A, 32'hffff_ffff);
    rd(irq_regs_pkg::OFF_EN_A, 32'h0000_00f1);
    wr(irq_regs_pkg::OFF_EN_B, 32'hffff_ffff);
    rd(irq_regs_pkg::OFF_EN_B, 32'h0000_0004);
    wr(irq_regs_pkg::OFF_REQ_A, 32'h0000_00ff);
    rd(irq_regs_pkg::OFF_REQ_A, 32'h0000_00f1);
    wr(irq_regs_pkg::OFF_REQ_B, 32'h0000_00ff);
    rd(irq_regs_pkg::OFF_REQ_B, 32'h0000_0004);
    // stale flags are dropped before the enables take effect
    wr(irq_regs_pkg::OFF_REQ_A, 32'h0000_0000);
    wr(irq_regs_pkg::OFF_REQ_B, 32'h0000_0000);
    rd(irq_regs_pkg::OFF_REQ_A, 32'h0000_0000);
    // one source at a time, so a crossed event wire shows up
    for (int i = 0; i < 6; i++) begin
      peer.pulse(6'(1 << i));
      settle;
      one_hot = ev_bits(i);
      rd(irq_regs_pkg::OFF_REQ_A, {24'h00_0000, one_hot[7:0]});
      rd(irq_regs_pkg::OFF_REQ_B, {24'h00_0000, one_hot[15:8]});
      wr(irq_regs_pkg::OFF_REQ_A, 32'h0000_0000);
      wr(irq_regs_pkg::OFF_REQ_B, 32'h0000_0000);
    end
    peer.pulse(6'h3f);
    settle;
    rd(irq_regs_pkg::OFF_REQ_A, 32'h0000_00f1);
    rd(irq_regs_pkg::OFF_REQ_B, 32'h0000_0004);
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    wr(irq_regs_pkg::OFF_CORE_CTRL, 32'h0000_0080);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    wr(irq_regs_pkg::OFF_CORE_CTRL, 32'h0000_0040);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    wr(irq_regs_pkg::OFF_CORE_CTRL, 32'h0000_00c0);
    settle;
    out_chk(periph_irq_req, 1'b1, irq, 1'b0);
    wr(irq_regs_pkg::OFF_REQ_A, 32'h0000_0000);
    settle;
    out_chk(periph_irq_req, 1'b1, irq, 1'b0);
    wr(irq_regs_pkg::OFF_EN_B, 32'h0000_0000);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    rd(irq_regs_pkg::OFF_STATUS, 32'h0000_00f5);
    wr(irq_regs_pkg::OFF_IRQ_EN, 32'h0000_0004);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b1);
    wr(irq_regs_pkg::OFF_IRQ_EN, 32'h0000_0000);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    wr(irq_regs_pkg::OFF_IRQ_EN, 32'h0000_0004);
    wr(irq_regs_pkg::OFF_CLEAR, 32'h0000_0004);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b0);
    rd(irq_regs_pkg::OFF_STATUS, 32'h0000_00f1);
    // unmapped address: error answer, no data, error bit in status
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'(e), 32'h1);
    chk(r, 32'h0000_0000);
    rd(irq_regs_pkg::OFF_STATUS, 32'h0000_00f3);
    wr(irq_regs_pkg::OFF_IRQ_EN, 32'h0000_0002);
    settle;
    out_chk(periph_irq_req, 1'b0, irq, 1'b1);
    do_reset;
    zero_all;
    conclude;
  end
endmodule : test_periph_irq_ctrl

/* rtl/apb_reg_front.sv */
// apb slave front end: one wait-free access phase, registered answer
module apb_reg_front (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  reg_access_if.front      bus
);
  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } front_state_type;

  front_state_type s_r;
  front_state_type s_nxt;
  logic            setup;
  logic            commit;

  assign setup          = psel && !penable;
  assign commit         = psel && penable && s_r.ready;
  assign bus.addr       = paddr;
  assign bus.wdata      = pwdata[7:0];
  // the access completes at the edge that sees pready, never earlier
  assign bus.take_wr    = commit && pwrite && !s_r.err;
  assign bus.bad_access = commit && s_r.err;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.ready = setup;
    if (setup) begin
      s_nxt.err   = !bus.hit;
      s_nxt.rdata = (pwrite || !bus.hit) ? irq_regs_pkg::RESET_WORD : {24'h00_0000, bus.rdata};
    end else if (commit) begin
      s_nxt.err = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.rdata;
  assign pready  = s_r.ready;
  assign pslverr = s_r.err;
endmodule : apb_reg_front

/* rtl/flag_bank.sv */
// eight sticky flags: hardware set wins over a software load or clear
module flag_bank (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] impl_mask,
  input  wire logic [7:0] set_vec,
  input  wire logic       wr_en,
  input  wire logic       clr_mode,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  typedef struct packed {
    logic [7:0] flags;
  } bank_state_type;

  bank_state_type s_r;
  bank_state_type s_nxt;
  logic [7:0]     base;

  always_comb begin
    base = s_r.flags;
    if (wr_en) begin
      base = clr_mode ? (s_r.flags & ~wr_data) : wr_data;
    end
    // unimplemented positions never hold a one
    s_nxt.flags = (base | set_vec) & impl_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.flags;
endmodule : flag_bank

/* rtl/irq_regs_pkg.sv */
// register map, bit positions and reset values of the peripheral interrupt block
package irq_regs_pkg;
  localparam logic [7:0] OFF_EN_A      = 8'h00;
  localparam logic [7:0] OFF_EN_B      = 8'h04;
  localparam logic [7:0] OFF_REQ_A     = 8'h08;
  localparam logic [7:0] OFF_REQ_B     = 8'h0c;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_CLEAR     = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h1c;

  localparam int BIT_T1_GATE  = 7;
  localparam int BIT_ADC      = 6;
  localparam int BIT_RX       = 5;
  localparam int BIT_TX       = 4;
  localparam int BIT_T1_OVF   = 0;
  localparam int BIT_LCD      = 2;
  localparam int BIT_GIE      = 7;
  localparam int BIT_PERIPH_GROUP_ENABLE     = 6;
  localparam int BIT_BUS_ERR  = 1;

  localparam logic [7:0]  MASK_A      = 8'hf1;
  localparam logic [7:0]  MASK_B      = 8'h04;
  localparam logic [7:0]  MASK_CTRL   = 8'hc0;
  localparam logic [7:0]  MASK_STATUS = 8'hf7;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
endpackage : irq_regs_pkg

/* rtl/periph_irq_ctrl.sv */
// peripheral interrupt enable and request registers with core request gating
// Notes on behaviour
// - no core request without peripheral group enable
// - flags set on events regardless of enables
// - enable a bit7 timer1 gate, bit0 overflow
// - enable a bit6 adc, bit5 rx, bit4 tx
// - bits 3..1 of enable a, request a read zero
// - enable b: only bit2 lcd, rest zero
// - request a mirrors enable a layout
// - request b: only bit2 lcd flag
// - flag one means pending, zero none
// - implemented bits read/write, reset to zero
// - global enable clear blocks, pending kept for later
module periph_irq_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer1_gate_event,
  input  wire logic        adc_event,
  input  wire logic        serial_rx_event,
  input  wire logic        serial_tx_event,
  input  wire logic        timer1_overflow_event,
  input  wire logic        lcd_event,
  output logic             periph_irq_req,
  output logic             irq
);
  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] ctrl;
    logic [7:0] irq_en;
    logic       req;
    logic       irq;
  } ctrl_state_type;

  ctrl_state_type s_r;
  ctrl_state_type s_nxt;
  reg_access_if   bus ();

  logic [7:0] req_a_q;
  logic [7:0] req_b_q;
  logic [7:0] status_q;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] set_status;
  logic       wr_req_a;
  logic       wr_req_b;
  logic       wr_clear;
  logic       global_irq_enable;
  logic       periph_group_enable;
  logic       any_pending;

  apb_reg_front u_front (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.front)
  );

  // peripheral events land in their flag positions whatever the enables hold
  always_comb begin
    set_a                             = 8'h00;
    set_b                             = 8'h00;
    set_a[irq_regs_pkg::BIT_T1_GATE]  = timer1_gate_event;
    set_a[irq_regs_pkg::BIT_ADC]      = adc_event;
    set_a[irq_regs_pkg::BIT_RX]       = serial_rx_event;
    set_a[irq_regs_pkg::BIT_TX]       = serial_tx_event;
    set_a[irq_regs_pkg::BIT_T1_OVF]   = timer1_overflow_event;
    set_b[irq_regs_pkg::BIT_LCD]      = lcd_event;
    set_status                        = set_a | set_b;
    set_status[irq_regs_pkg::BIT_BUS_ERR] = bus.bad_access;
  end

  assign wr_req_a = bus.take_wr && (bus.addr == irq_regs_pkg::OFF_REQ_A);
  assign wr_req_b = bus.take_wr && (bus.addr == irq_regs_pkg::OFF_REQ_B);
  assign wr_clear = bus.take_wr && (bus.addr == irq_regs_pkg::OFF_CLEAR);

  // masks keep unimplemented request bits at zero
  flag_bank u_req_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .impl_mask (irq_regs_pkg::MASK_A),
    .set_vec   (set_a),
    .wr_en     (wr_req_a),
    .clr_mode  (1'b0),
    .wr_data   (bus.wdata),
    .q         (req_a_q)
  );

  flag_bank u_req_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .impl_mask (irq_regs_pkg::MASK_B),
    .set_vec   (set_b),
    .wr_en     (wr_req_b),
    .clr_mode  (1'b0),
    .wr_data   (bus.wdata),
    .q         (req_b_q)
  );

  // sticky event status, cleared by writing ones to the clear register
  flag_bank u_status (
    .pclk      (pclk),
    .presetn   (presetn),
    .impl_mask (irq_regs_pkg::MASK_STATUS),
    .set_vec   (set_status),
    .wr_en     (wr_clear),
    .clr_mode  (1'b1),
    .wr_data   (bus.wdata),
    .q         (status_q)
  );

  assign global_irq_enable         = s_r.ctrl[irq_regs_pkg::BIT_GIE];
  assign periph_group_enable        = s_r.ctrl[irq_regs_pkg::BIT_PERIPH_GROUP_ENABLE];
  assign any_pending = |((req_a_q & s_r.en_a) | (req_b_q & s_r.en_b));

  always_comb begin
    bus.hit   = 1'b1;
    bus.rdata = 8'h00;
    unique case (bus.addr)
      irq_regs_pkg::OFF_EN_A:      bus.rdata = s_r.en_a;
      irq_regs_pkg::OFF_EN_B:      bus.rdata = s_r.en_b;
      irq_regs_pkg::OFF_REQ_A:     bus.rdata = req_a_q;
      irq_regs_pkg::OFF_REQ_B:     bus.rdata = req_b_q;
      irq_regs_pkg::OFF_CORE_CTRL: bus.rdata = s_r.ctrl;
      irq_regs_pkg::OFF_STATUS:    bus.rdata = status_q;
      irq_regs_pkg::OFF_CLEAR:     bus.rdata = 8'h00;
      irq_regs_pkg::OFF_IRQ_EN:    bus.rdata = s_r.irq_en;
      default:                     bus.hit   = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    if (bus.take_wr) begin
      unique case (bus.addr)
        irq_regs_pkg::OFF_EN_A:      s_nxt.en_a   = bus.wdata & irq_regs_pkg::MASK_A;
        irq_regs_pkg::OFF_EN_B:      s_nxt.en_b   = bus.wdata & irq_regs_pkg::MASK_B;
        irq_regs_pkg::OFF_CORE_CTRL: s_nxt.ctrl   = bus.wdata & irq_regs_pkg::MASK_CTRL;
        irq_regs_pkg::OFF_IRQ_EN:    s_nxt.irq_en = bus.wdata & irq_regs_pkg::MASK_STATUS;
        default:                     s_nxt.ctrl   = s_r.ctrl;
      endcase
    end
    // flags stay pending while gated, so a later enable still raises the request
    s_nxt.req = global_irq_enable && periph_group_enable && any_pending;
    s_nxt.irq = |(status_q & s_r.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign periph_irq_req = s_r.req;
  assign irq            = s_r.irq;

  a_group_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    !periph_group_enable |=> !periph_irq_req
  ) else $error("core request raised with group enable clear");

  a_flag_set_free: assert property (
    @(posedge pclk) disable iff (!presetn)
    (timer1_gate_event && !wr_req_a) |=> req_a_q[irq_regs_pkg::BIT_T1_GATE]
  ) else $error("gate event did not set its flag");

  a_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (bus.take_wr && bus.addr == irq_regs_pkg::OFF_EN_A)
      |=> s_r.en_a == ($past(bus.wdata) & irq_regs_pkg::MASK_A)
  ) else $error("enable a write not stored");

  a_adc_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    adc_event |=> req_a_q[irq_regs_pkg::BIT_ADC]
  ) else $error("adc event lost");

  a_unimpl_a_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    req_a_q[3:1] == 3'b000 && s_r.en_a[3:1] == 3'b000
  ) else $error("unimplemented bit of bank a set");

  a_enable_b_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_r.en_b & 8'hfb) == 8'h00
  ) else $error("enable b holds an unimplemented bit");

  a_request_b_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (req_b_q & 8'hfb) == 8'h00
  ) else $error("request b holds an unimplemented bit");

  a_pending_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == irq_regs_pkg::OFF_REQ_A)
      |=> prdata == {24'h00_0000, $past(req_a_q)}
  ) else $error("request a read back wrong");

  a_reset_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(!presetn) |-> (s_r.en_a == 8'h00 && s_r.en_b == 8'h00 && !periph_irq_req)
  ) else $error("enables not zero after reset");

  a_global_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    // a software write may legally drop flags, so only untouched cycles are held
    (!global_irq_enable && any_pending && !wr_req_a && !wr_req_b)
      |=> (!periph_irq_req && (|(req_a_q | req_b_q)))
  ) else $error("request taken or lost while global enable clear");

  a_combined_req: assert property (
    @(posedge pclk) disable iff (!presetn)
    (global_irq_enable && periph_group_enable && any_pending) |=> periph_irq_req
  ) else $error("gated request missing");
endmodule : periph_irq_ctrl

/* rtl/reg_access_if.sv */
// carrier between the bus front end and the interrupt register file
interface reg_access_if;
  logic       take_wr;
  logic       bad_access;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;

  modport front (
    output take_wr,
    output bad_access,
    output addr,
    output wdata,
    input  rdata,
    input  hit
  );
  modport regs (
    input  take_wr,
    input  bad_access,
    input  addr,
    input  wdata,
    output rdata,
    output hit
  );
endinterface : reg_access_if
